// >>> astr_far_end.sv
module astr_far_end (
    input wire logic i_clk,
    input wire logic i_line,
    output logic o_line
);
    timeunit 1ns;
    timeprecision 1ps;
    // one bit at divisor 0
    localparam int BIT_CLKS = 16;

    // idle line is marking
    initial o_line = 1'h1;

    task automatic send_frame(input logic [7:0] d, input logic p, input logic s);
        logic [10:0] bits;
        bits = {s, p, d, 1'h0};
        for (int i = 0; i < 11; i++) begin
            @(posedge i_clk) o_line <= bits[i];
            repeat (BIT_CLKS - 1) @(posedge i_clk);
        end
        @(posedge i_clk) o_line <= 1'h1;
    endtask

    // samples mid-bit, returns at mid-stop so a chained start is not missed
    task automatic take_frame(output logic [10:0] bits);
        int n;
        bits = 11'h7FF;
        n = 0;
        while (i_line !== 1'h0 && n < 300) begin
            @(negedge i_clk);
            n++;
        end
        if (n < 300) begin
            repeat (BIT_CLKS / 2) @(negedge i_clk);
            for (int i = 0; i < 11; i++) begin
                bits[i] = i_line;
                if (i < 10) repeat (BIT_CLKS) @(negedge i_clk);
            end
        end
    endtask
endmodule

// >>> astr_pkg.sv
package astr_pkg;

    localparam int ASTR_DATA_W = 8;
    localparam int ASTR_DIV_W = 8;

    // oversampling phases within one bit
    localparam int ASTR_OVERSAMPLE = 16;
    localparam logic [3:0] ASTR_PHASE_LAST = 4'hF;
    localparam logic [3:0] ASTR_PHASE_SAMPLE = 4'h7;
    localparam logic [3:0] ASTR_PHASE_SCK_RISE = 4'h8;

    // index of the last data bit for each character length
    localparam logic [2:0] ASTR_LAST_BIT_7 = 3'h6;
    localparam logic [2:0] ASTR_LAST_BIT_8 = 3'h7;

    // clock source select {hi, lo}
    localparam logic [1:0] ASTR_CLK_INT = 2'h0;
    localparam logic [1:0] ASTR_CLK_INT_OUT = 2'h1;

    // reset values of the transmit status flags, pin levels, divider count and data registers
    localparam logic ASTR_RST_TX_EMPTY = 1'h1;
    localparam logic ASTR_RST_TX_DONE = 1'h1;
    localparam logic ASTR_RST_LINE = 1'h1;
    localparam logic ASTR_RST_OE_N = 1'h1;
    localparam logic [ASTR_DIV_W-1:0] ASTR_RST_DIV_CNT = 8'h00;
    localparam logic [ASTR_DATA_W-1:0] ASTR_RST_DATA = 8'h00;

    typedef enum logic [2:0] {
        ASTR_TX_IDLE,
        ASTR_TX_START,
        ASTR_TX_DATA,
        ASTR_TX_PAR,
        ASTR_TX_STOP
    } astr_tx_st_t;

    typedef enum logic [2:0] {
        ASTR_RX_IDLE,
        ASTR_RX_START,
        ASTR_RX_DATA,
        ASTR_RX_PAR,
        ASTR_RX_STOP
    } astr_rx_st_t;

    typedef struct packed {
        logic clock_source_select_hi;
        logic clock_source_select_lo;
        logic seven_bit;
        logic parity_en;
        logic parity_odd;
        logic mp_en;
        logic two_stop;
        logic tx_enable;
        logic rx_enable;
        logic tx_empty_irq_en;
        logic rx_irq_en;
        logic tx_done_irq_en;
        logic mp_bit_tx;
    } astr_cfg_t;

    typedef struct packed {
        logic tx_empty_flag;
        logic tx_done_flag;
        logic rx_full_flag;
        logic overrun_flag;
        logic framing_error_flag;
        logic parity_error_flag;
    } astr_status_t;

    typedef struct packed {
        logic tx_empty_irq;
        logic tx_done_irq;
        logic rx_full_irq;
        logic rx_error_irq;
    } astr_irq_t;

    typedef struct packed {
        astr_tx_st_t tx_st;
        logic [3:0] tx_phase;
        logic [2:0] tx_bit;
        logic tx_stop2;
        logic [ASTR_DATA_W-1:0] tx_shifter;
        logic tx_par_bit;
        logic [ASTR_DATA_W-1:0] tx_holding_reg;
        logic txd;
        logic txd_oe_n;
        logic sck;
        logic sck_oe_n;
        astr_rx_st_t rx_st;
        logic [3:0] rx_phase;
        logic [2:0] rx_bit;
        logic [ASTR_DATA_W-1:0] rx_shifter;
        logic rx_par;
        logic rxd_prev;
        logic [ASTR_DATA_W-1:0] rx_holding_reg;
        astr_status_t status;
        astr_irq_t irq;
    } astr_core_t;

    typedef struct packed {
        logic [ASTR_DIV_W-1:0] cnt;
        logic sync1;
        logic sync2;
        logic sync3;
        logic tick;
    } astr_tick_t;

endpackage

// >>> astr_serial_txrx.sv
// Contract
// RULE_01 - external clock runs at sixteen times bitrate
// RULE_02 - clock output at bitrate, rising mid-bit
// RULE_03 - transmit disable sets empty, resets shifter
// RULE_04 - receive disable keeps flags and data
// RULE_05 - disable both before changing format
// RULE_06 - clock output starts at once when selected
// RULE_07 - configure clock, format, divisor in order
// RULE_08 - wait one bit before enabling
// RULE_09 - enable takes pin: marking, await start
// RULE_10 - empty cleared: load shifter, set empty
// RULE_11 - start, data LSB first, parity, stops
// RULE_12 - at stop: chain next frame or done
// RULE_13 - DMA write clears empty flag itself
// RULE_14 - resync on start, shift LSB first
// RULE_15 - sample on eighth oversample tick
// RULE_16 - check parity against even/odd setting
// RULE_17 - first stop bit must be high
// RULE_18 - good frame loads data, sets full
// RULE_19 - full at frame end: overrun, discard
// RULE_20 - framing/parity error still load data
// RULE_21 - error flags block reception until cleared
// RULE_22 - full and error interrupt requests
// RULE_23 - software empties buffer before next stop
// RULE_24 - DMA read clears full flag itself
// RULE_25 - external clock must keep running
// RULE_26 - internal tick from system clock divisor
module astr_serial_txrx #(
    parameter int DIV_W = astr_pkg::ASTR_DIV_W
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire astr_pkg::astr_cfg_t i_cfg,
    input wire logic [DIV_W-1:0] i_baud_div,
    input wire logic i_tx_wr,
    input wire logic i_tx_dma_wr,
    input wire logic [astr_pkg::ASTR_DATA_W-1:0] i_tx_data,
    input wire logic i_tx_empty_clr,
    input wire logic i_rx_full_clr,
    input wire logic i_rx_dma_rd,
    input wire logic i_overrun_clr,
    input wire logic i_framing_clr,
    input wire logic i_parity_clr,
    input wire logic i_rxd,
    input wire logic i_sck,
    output logic o_txd,
    output logic o_txd_oe_n,
    output logic o_sck,
    output logic o_sck_oe_n,
    output logic [astr_pkg::ASTR_DATA_W-1:0] o_rx_data,
    output astr_pkg::astr_status_t o_status,
    output astr_pkg::astr_irq_t o_irq
);

    localparam astr_pkg::astr_core_t CORE_RST = '{
        tx_st: astr_pkg::ASTR_TX_IDLE, tx_phase: 4'h0, tx_bit: 3'h0, tx_stop2: 1'b0,
        tx_shifter: astr_pkg::ASTR_RST_DATA, tx_par_bit: 1'b0, tx_holding_reg: astr_pkg::ASTR_RST_DATA,
        txd: astr_pkg::ASTR_RST_LINE, txd_oe_n: astr_pkg::ASTR_RST_OE_N,
        sck: astr_pkg::ASTR_RST_LINE, sck_oe_n: astr_pkg::ASTR_RST_OE_N,
        rx_st: astr_pkg::ASTR_RX_IDLE, rx_phase: 4'h0, rx_bit: 3'h0,
        rx_shifter: astr_pkg::ASTR_RST_DATA, rx_par: 1'b0, rxd_prev: astr_pkg::ASTR_RST_LINE,
        rx_holding_reg: astr_pkg::ASTR_RST_DATA,
        status: '{tx_empty_flag: astr_pkg::ASTR_RST_TX_EMPTY, tx_done_flag: astr_pkg::ASTR_RST_TX_DONE,
                  rx_full_flag: 1'b0, overrun_flag: 1'b0, framing_error_flag: 1'b0, parity_error_flag: 1'b0},
        irq: '{tx_empty_irq: 1'b0, tx_done_irq: 1'b0, rx_full_irq: 1'b0, rx_error_irq: 1'b0}
    };

    astr_pkg::astr_core_t st_ff;
    astr_pkg::astr_core_t nxt;
    logic tick;
    logic clk_ext;
    logic clk_out;
    logic tx_bit_end;
    logic [2:0] last_bit;
    logic [astr_pkg::ASTR_DATA_W-1:0] tx_masked;
    logic rx_err_any;
    logic rx_fin;
    logic stop_ok;
    logic par_ok;

    assign clk_ext = i_cfg.clock_source_select_hi;
    assign clk_out = ({i_cfg.clock_source_select_hi, i_cfg.clock_source_select_lo} == astr_pkg::ASTR_CLK_INT_OUT);
    assign tx_bit_end = tick && (st_ff.tx_phase == astr_pkg::ASTR_PHASE_LAST);
    assign last_bit = i_cfg.seven_bit ? astr_pkg::ASTR_LAST_BIT_7 : astr_pkg::ASTR_LAST_BIT_8;
    assign tx_masked = i_cfg.seven_bit ? {1'b0, st_ff.tx_holding_reg[6:0]} : st_ff.tx_holding_reg;
    assign rx_err_any = st_ff.status.overrun_flag | st_ff.status.framing_error_flag
                        | st_ff.status.parity_error_flag;
    assign stop_ok = i_rxd;
    assign par_ok = !i_cfg.parity_en || i_cfg.mp_en || (((^st_ff.rx_shifter) ^ st_ff.rx_par) == i_cfg.parity_odd);

    astr_tick_gen #(
        .DIV_W(DIV_W)
    ) u_tick (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_div(i_baud_div),
        .i_ext_sel(clk_ext),
        .i_sck(i_sck),
        .o_tick(tick)
    );

    always_comb begin
        nxt = st_ff;
        rx_fin = 1'b0;
        // ---------------- transmitter ----------------
        if (i_tx_wr || i_tx_dma_wr) begin
            nxt.tx_holding_reg = i_tx_data;
        end
        if (i_tx_empty_clr || i_tx_dma_wr) begin
            nxt.status.tx_empty_flag = 1'b0; // RULE_13
            nxt.status.tx_done_flag = 1'b0;
        end
        if (tick) begin
            nxt.tx_phase = st_ff.tx_phase + 4'h1;
        end
        if (!i_cfg.tx_enable) begin
            nxt.tx_st = astr_pkg::ASTR_TX_IDLE; // RULE_03
            nxt.tx_shifter = '0;
            nxt.tx_stop2 = 1'b0;
            nxt.tx_bit = 3'h0;
            nxt.status.tx_empty_flag = 1'b1;
        end else if (tx_bit_end) begin
            case (st_ff.tx_st)
                astr_pkg::ASTR_TX_IDLE: begin
                    if (!st_ff.status.tx_empty_flag) begin
                        nxt.tx_st = astr_pkg::ASTR_TX_START; // RULE_10
                    end
                end
                astr_pkg::ASTR_TX_START: begin
                    nxt.tx_st = astr_pkg::ASTR_TX_DATA; // RULE_11
                    nxt.tx_bit = 3'h0;
                end
                astr_pkg::ASTR_TX_DATA: begin
                    nxt.tx_shifter = {1'b0, st_ff.tx_shifter[astr_pkg::ASTR_DATA_W-1:1]}; // RULE_11
                    if (st_ff.tx_bit == last_bit) begin
                        nxt.tx_st = (i_cfg.parity_en || i_cfg.mp_en) ? astr_pkg::ASTR_TX_PAR : astr_pkg::ASTR_TX_STOP;
                        nxt.tx_stop2 = 1'b0;
                    end else begin
                        nxt.tx_bit = st_ff.tx_bit + 3'h1;
                    end
                end
                astr_pkg::ASTR_TX_PAR: begin
                    nxt.tx_st = astr_pkg::ASTR_TX_STOP;
                    nxt.tx_stop2 = 1'b0;
                end
                astr_pkg::ASTR_TX_STOP: begin
                    if (i_cfg.two_stop && !st_ff.tx_stop2) begin
                        nxt.tx_stop2 = 1'b1;
                    end else if (!st_ff.status.tx_empty_flag) begin
                        nxt.tx_st = astr_pkg::ASTR_TX_START; // RULE_12
                    end else begin
                        nxt.tx_st = astr_pkg::ASTR_TX_IDLE; // RULE_12
                        nxt.status.tx_done_flag = 1'b1;
                    end
                end
                default: begin
                    nxt.tx_st = astr_pkg::ASTR_TX_IDLE;
                end
            endcase
            if (nxt.tx_st == astr_pkg::ASTR_TX_START) begin
                // shifter load; hardware set wins over a same-cycle clear
                nxt.tx_shifter = tx_masked; // RULE_10
                nxt.tx_par_bit = i_cfg.mp_en ? i_cfg.mp_bit_tx : ((^tx_masked) ^ i_cfg.parity_odd);
                nxt.status.tx_empty_flag = 1'b1;
                nxt.status.tx_done_flag = 1'b0;
            end
        end
        case (nxt.tx_st)
            astr_pkg::ASTR_TX_START: nxt.txd = 1'b0;
            astr_pkg::ASTR_TX_DATA: nxt.txd = nxt.tx_shifter[0];
            astr_pkg::ASTR_TX_PAR: nxt.txd = nxt.tx_par_bit;
            default: nxt.txd = 1'b1; // RULE_09
        endcase
        nxt.txd_oe_n = !i_cfg.tx_enable; // RULE_09
        nxt.sck = clk_out ? (nxt.tx_phase >= astr_pkg::ASTR_PHASE_SCK_RISE) : 1'b1; // RULE_02
        nxt.sck_oe_n = !clk_out; // RULE_06
        // ---------------- receiver ----------------
        nxt.rxd_prev = i_rxd;
        if (i_rx_full_clr || i_rx_dma_rd) begin
            nxt.status.rx_full_flag = 1'b0; // RULE_24
        end
        if (i_overrun_clr) begin
            nxt.status.overrun_flag = 1'b0;
        end
        if (i_framing_clr) begin
            nxt.status.framing_error_flag = 1'b0;
        end
        if (i_parity_clr) begin
            nxt.status.parity_error_flag = 1'b0;
        end
        if (!i_cfg.rx_enable) begin
            nxt.rx_st = astr_pkg::ASTR_RX_IDLE; // RULE_04
        end else if (st_ff.rx_st == astr_pkg::ASTR_RX_IDLE) begin
            if (st_ff.rxd_prev && !i_rxd && !rx_err_any) begin
                nxt.rx_st = astr_pkg::ASTR_RX_START; // RULE_14 RULE_21
                nxt.rx_phase = 4'h0;
                nxt.rx_shifter = '0;
                nxt.rx_par = 1'b0;
            end
        end else if (tick) begin
            nxt.rx_phase = st_ff.rx_phase + 4'h1;
            if (st_ff.rx_phase == astr_pkg::ASTR_PHASE_SAMPLE) begin
                case (st_ff.rx_st)
                    astr_pkg::ASTR_RX_START: begin
                        // a high start sample is a glitch, not a frame
                        nxt.rx_st = i_rxd ? astr_pkg::ASTR_RX_IDLE : astr_pkg::ASTR_RX_DATA; // RULE_15
                        nxt.rx_bit = 3'h0;
                    end
                    astr_pkg::ASTR_RX_DATA: begin
                        nxt.rx_shifter[st_ff.rx_bit] = i_rxd; // RULE_14
                        if (st_ff.rx_bit == last_bit) begin
                            nxt.rx_st = (i_cfg.parity_en || i_cfg.mp_en) ? astr_pkg::ASTR_RX_PAR
                                                                          : astr_pkg::ASTR_RX_STOP;
                        end else begin
                            nxt.rx_bit = st_ff.rx_bit + 3'h1;
                        end
                    end
                    astr_pkg::ASTR_RX_PAR: begin
                        nxt.rx_par = i_rxd;
                        nxt.rx_st = astr_pkg::ASTR_RX_STOP;
                    end
                    default: begin
                        // only the first stop bit is looked at
                        nxt.rx_st = astr_pkg::ASTR_RX_IDLE; // RULE_17
                        rx_fin = 1'b1;
                    end
                endcase
            end
        end
        if (rx_fin) begin
            if (st_ff.status.rx_full_flag) begin
                nxt.status.overrun_flag = 1'b1; // RULE_19
            end else begin
                nxt.rx_holding_reg = st_ff.rx_shifter; // RULE_20
                if (!stop_ok) begin
                    nxt.status.framing_error_flag = 1'b1; // RULE_20
                end
                if (!par_ok) begin
                    nxt.status.parity_error_flag = 1'b1; // RULE_16
                end
                if (stop_ok && par_ok && !rx_err_any) begin
                    nxt.status.rx_full_flag = 1'b1; // RULE_18
                end
            end
        end
        // ---------------- interrupt requests ----------------
        nxt.irq.tx_empty_irq = nxt.status.tx_empty_flag & i_cfg.tx_empty_irq_en & i_cfg.tx_enable; // RULE_10
        nxt.irq.tx_done_irq = nxt.status.tx_done_flag & i_cfg.tx_done_irq_en; // RULE_12
        nxt.irq.rx_full_irq = nxt.status.rx_full_flag & i_cfg.rx_irq_en; // RULE_22
        nxt.irq.rx_error_irq = (nxt.status.overrun_flag | nxt.status.framing_error_flag
                                | nxt.status.parity_error_flag) & i_cfg.rx_irq_en; // RULE_22
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_ff <= CORE_RST;
        end else begin
            st_ff <= nxt;
        end
    end

    assign o_txd = st_ff.txd;
    assign o_txd_oe_n = st_ff.txd_oe_n;
    assign o_sck = st_ff.sck;
    assign o_sck_oe_n = st_ff.sck_oe_n;
    assign o_rx_data = st_ff.rx_holding_reg;
    assign o_status = st_ff.status;
    assign o_irq = st_ff.irq;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);

    a_tx_off_empty: assert property (!i_cfg.tx_enable // RULE_03
        |=> st_ff.status.tx_empty_flag && st_ff.tx_st == astr_pkg::ASTR_TX_IDLE)
        else $error("empty flag not forced by transmit disable");
    a_rx_off_hold: assert property (!i_cfg.rx_enable && !i_rx_full_clr && !i_rx_dma_rd // RULE_04
        |=> $stable(st_ff.status.rx_full_flag) && $stable(st_ff.rx_holding_reg))
        else $error("receive state changed while receive disabled");
    a_idle_marking: assert property (st_ff.tx_st == astr_pkg::ASTR_TX_IDLE |-> st_ff.txd) // RULE_09
        else $error("line not marking while idle");
    a_start_load: assert property ($changed(st_ff.tx_st) && st_ff.tx_st == astr_pkg::ASTR_TX_START // RULE_10
        |-> st_ff.status.tx_empty_flag && !$past(st_ff.status.tx_empty_flag) && !st_ff.txd)
        else $error("frame start without empty flag handoff");
    a_stop_high: assert property (st_ff.tx_st == astr_pkg::ASTR_TX_STOP |-> st_ff.txd) // RULE_11
        else $error("stop bit not high");
    a_sck_center: assert property (clk_out && $rose(st_ff.sck) // RULE_02
        |-> st_ff.tx_phase == astr_pkg::ASTR_PHASE_SCK_RISE)
        else $error("clock output edge not mid bit");
    a_sck_drive: assert property (clk_out |=> !o_sck_oe_n) // RULE_06
        else $error("clock output not driven");
    // a disable during the stop bit ends the frame without done
    a_tx_done: assert property (i_cfg.tx_enable && st_ff.tx_st == astr_pkg::ASTR_TX_STOP // RULE_12
        ##1 st_ff.tx_st == astr_pkg::ASTR_TX_IDLE |-> st_ff.status.tx_done_flag)
        else $error("done flag missing after last stop");
    a_overrun_keep: assert property (rx_fin && st_ff.status.rx_full_flag // RULE_19
        |=> st_ff.status.overrun_flag && $stable(st_ff.rx_holding_reg))
        else $error("overrun not flagged or data overwritten");
    a_rx_good: assert property (rx_fin && !st_ff.status.rx_full_flag && stop_ok && par_ok && !rx_err_any // RULE_18
        |=> st_ff.status.rx_full_flag && st_ff.rx_holding_reg == $past(st_ff.rx_shifter))
        else $error("good frame not delivered");
    a_err_block: assert property (rx_err_any && st_ff.rx_st == astr_pkg::ASTR_RX_IDLE // RULE_21
        && !i_overrun_clr && !i_framing_clr && !i_parity_clr |=> st_ff.rx_st == astr_pkg::ASTR_RX_IDLE)
        else $error("reception restarted with error pending");
    a_err_irq: assert property (rx_err_any && i_cfg.rx_irq_en // RULE_22
        && !i_overrun_clr && !i_framing_clr && !i_parity_clr |=> st_ff.irq.rx_error_irq)
        else $error("error interrupt not requested");

    c_back_to_back: cover property (st_ff.tx_st == astr_pkg::ASTR_TX_STOP ##1 st_ff.tx_st == astr_pkg::ASTR_TX_START);
    c_rx_full: cover property ($rose(st_ff.status.rx_full_flag));
    c_overrun: cover property ($rose(st_ff.status.overrun_flag));
    c_framing: cover property ($rose(st_ff.status.framing_error_flag));

endmodule

// >>> astr_serial_txrx_bench.sv
module astr_serial_txrx_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'h0;
    logic rst_n = 1'h0;
    astr_pkg::astr_cfg_t cfg = '0;
    logic tx_wr = 1'h0;
    logic tx_dma_wr = 1'h0;
    logic tx_empty_clr = 1'h0;
    logic [7:0] tx_data = 8'h00;
    logic [4:0] clrs = 5'h00;
    logic [7:0] baud_div = 8'h00;
    logic sck_in = 1'h0;
    logic sck_run = 1'h0;
    logic rxd;
    logic txd;
    logic txd_oe_n;
    logic sck;
    logic sck_oe_n;
    logic [7:0] rx_data;
    astr_pkg::astr_status_t st;
    astr_pkg::astr_irq_t irq;
    int failures = 0;
    int n_tests = 0;

    always #2 clk_sys = ~clk_sys;

    // external 16x clock, one rising edge every two system clocks, never stopped once started
    always @(posedge clk_sys) if (sck_run) sck_in <= ~sck_in;

    astr_serial_txrx u_dut (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_cfg(cfg), .i_baud_div(baud_div),
        .i_tx_wr(tx_wr), .i_tx_dma_wr(tx_dma_wr), .i_tx_data(tx_data), .i_tx_empty_clr(tx_empty_clr),
        .i_rx_full_clr(clrs[4]), .i_rx_dma_rd(clrs[3]), .i_overrun_clr(clrs[2]), .i_framing_clr(clrs[1]),
        .i_parity_clr(clrs[0]), .i_rxd(rxd), .i_sck(sck_in), .o_txd(txd), .o_txd_oe_n(txd_oe_n),
        .o_sck(sck), .o_sck_oe_n(sck_oe_n), .o_rx_data(rx_data), .o_status(st), .o_irq(irq));

    astr_far_end u_far (.i_clk(clk_sys), .i_line(txd), .o_line(rxd));

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic clr(input logic [4:0] v);
        @(posedge clk_sys) clrs <= v;
        @(posedge clk_sys) clrs <= 5'h00;
        tick(1);
    endtask

    task automatic t_tx_chain;
        logic [10:0] f1;
        logic [10:0] f2;
        @(posedge clk_sys) {tx_dma_wr, tx_data} <= {1'h1, 8'hA5};
        @(posedge clk_sys) tx_dma_wr <= 1'h0;
        fork
            begin
                u_far.take_frame(f1);
                chk(11'(st.tx_done_flag), 11'h000);
                u_far.take_frame(f2);
            end
            begin
                tick(40);
                chk(11'(st.tx_empty_flag), 11'h001);
                @(posedge clk_sys) {tx_wr, tx_empty_clr, tx_data} <= {2'h3, 8'h3E};
                @(posedge clk_sys) {tx_wr, tx_empty_clr} <= 2'h0;
            end
        join
        chk(f1, {1'h1, ^8'hA5, 8'hA5, 1'h0});
        chk(f2, {1'h1, ^8'h3E, 8'h3E, 1'h0});
        tick(16);
        chk({st.tx_done_flag, txd}, 11'h003);
    endtask

    task automatic t_tx_abort;
        @(posedge clk_sys) {tx_dma_wr, tx_data} <= {1'h1, 8'h00};
        @(posedge clk_sys) tx_dma_wr <= 1'h0;
        tick(40);
        @(posedge clk_sys) tx_dma_wr <= 1'h1;
        @(posedge clk_sys) {tx_dma_wr, cfg.tx_enable} <= 2'h0;
        tick(3);
        chk({st.tx_empty_flag, txd}, 11'h003);
        @(posedge clk_sys) cfg.tx_enable <= 1'h1;
        tick(60);
        chk({st.tx_empty_flag, txd, txd_oe_n}, 11'h006);
    endtask

    // tx done stays clear here: the aborted frame never reached its stop bit
    task automatic t_rx;
        u_far.send_frame(8'h3C, ^8'h3C, 1'h1);
        tick(2);
        chk({st.rx_full_flag, irq.rx_full_irq, rx_data}, 11'h33C);
        u_far.send_frame(8'hC3, ^8'hC3, 1'h1);
        tick(2);
        chk({st.overrun_flag, irq.rx_error_irq, rx_data}, 11'h33C);
        @(posedge clk_sys) cfg.rx_enable <= 1'h0;
        tick(20);
        chk({st.rx_full_flag, st.overrun_flag, rx_data}, 11'h33C);
        @(posedge clk_sys) cfg.rx_enable <= 1'h1;
        clr(5'h0C);
        chk(11'(st), 11'h020);
        u_far.send_frame(8'h5A, ~^8'h5A, 1'h1);
        tick(2);
        chk({st.parity_error_flag, st.rx_full_flag, rx_data}, 11'h25A);
        u_far.send_frame(8'h11, ^8'h11, 1'h1);
        tick(2);
        chk({st.rx_full_flag, rx_data}, 11'h05A);
        clr(5'h01);
        u_far.send_frame(8'h81, ^8'h81, 1'h0);
        tick(2);
        chk({st.framing_error_flag, st.rx_full_flag, rx_data}, 11'h281);
        clr(5'h02);
        chk(11'(st), 11'h020);
    endtask

    // seven data bits, odd parity, two stops, both directions
    task automatic t_fmt7;
        logic [10:0] f;
        @(posedge clk_sys) cfg <= '0;
        @(posedge clk_sys) {cfg.seven_bit, cfg.parity_en, cfg.parity_odd, cfg.two_stop} <= 4'hF;
        tick(20);
        @(posedge clk_sys) {cfg.tx_enable, cfg.rx_enable, cfg.tx_empty_irq_en, cfg.tx_done_irq_en} <= 4'hF;
        @(posedge clk_sys) {tx_dma_wr, tx_data} <= {1'h1, 8'hB5};
        @(posedge clk_sys) tx_dma_wr <= 1'h0;
        u_far.take_frame(f);
        chk(f, {3'h7, 7'h35, 1'h0});
        tick(40);
        chk({irq.tx_empty_irq, irq.tx_done_irq, st.tx_done_flag}, 11'h007);
        u_far.send_frame(8'hB5, 1'h1, 1'h1);
        tick(2);
        chk({st.rx_full_flag, st.parity_error_flag, rx_data}, 11'h235);
    endtask

    task automatic t_sck_out;
        int rises;
        logic prev;
        @(posedge clk_sys) cfg <= '0;
        tick(2);
        @(posedge clk_sys) cfg.clock_source_select_lo <= 1'h1;
        tick(3);
        chk(11'(sck_oe_n), 11'h000);
        rises = 0;
        prev = sck;
        repeat (64) begin
            @(negedge clk_sys);
            if (prev === 1'h0 && sck === 1'h1) rises++;
            prev = sck;
        end
        chk(11'(rises), 11'h004);
    endtask

    // sends all ones and counts the system clocks of the low start bit
    task automatic start_width(output int w);
        int n;
        @(posedge clk_sys) {tx_dma_wr, tx_data} <= {1'h1, 8'hFF};
        @(posedge clk_sys) tx_dma_wr <= 1'h0;
        w = 0;
        n = 0;
        while (txd !== 1'h0 && n < 200) begin
            @(negedge clk_sys);
            n++;
        end
        while (txd === 1'h0 && w < 200) begin
            @(negedge clk_sys);
            w++;
        end
    endtask

    // divisor 1 and an external clock at half the system rate both give 32 clocks a bit
    task automatic t_clk_src;
        int w;
        @(posedge clk_sys) cfg <= '0;
        baud_div <= 8'h01;
        tick(40);
        @(posedge clk_sys) cfg.tx_enable <= 1'h1;
        start_width(w);
        chk(11'(w), 11'h020);
        @(posedge clk_sys) cfg <= '0;
        @(posedge clk_sys) {cfg.clock_source_select_hi, sck_run} <= 2'h3;
        tick(40);
        @(posedge clk_sys) cfg.tx_enable <= 1'h1;
        start_width(w);
        chk(11'(w), 11'h020);
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        tally_and_finish();
    end

    initial begin
        tick(10);
        @(posedge clk_sys) rst_n <= 1'h1;
        tick(1);
        chk({txd, st.tx_empty_flag, st.tx_done_flag}, 11'h007);
        @(posedge clk_sys) cfg.parity_en <= 1'h1;
        tick(20);
        @(posedge clk_sys) {cfg.tx_enable, cfg.rx_enable, cfg.rx_irq_en} <= 3'h7;
        tick(3);
        chk({txd_oe_n, txd}, 11'h001);
        t_tx_chain();
        t_tx_abort();
        t_rx();
        t_fmt7();
        t_sck_out();
        t_clk_src();
        tally_and_finish();
    end
endmodule

// >>> astr_tick_gen.sv
module astr_tick_gen #(
    parameter int DIV_W = astr_pkg::ASTR_DIV_W
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic [DIV_W-1:0] i_div,
    input wire logic i_ext_sel,
    input wire logic i_sck,
    output logic o_tick
);

    astr_pkg::astr_tick_t st_ff;
    astr_pkg::astr_tick_t nxt;

    always_comb begin
        nxt = st_ff;
        nxt.sync1 = i_sck;
        nxt.sync2 = st_ff.sync1;
        nxt.sync3 = st_ff.sync2;
        nxt.tick = 1'b0;
        if (i_ext_sel) begin
            // one tick per rising edge of the external 16x clock
            nxt.cnt = '0;
            nxt.tick = st_ff.sync2 & ~st_ff.sync3; // RULE_01
        end else if (st_ff.cnt >= i_div) begin
            nxt.cnt = '0;
            nxt.tick = 1'b1; // RULE_26
        end else begin
            nxt.cnt = st_ff.cnt + 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_ff <= '{cnt: astr_pkg::ASTR_RST_DIV_CNT, sync1: 1'b0, sync2: 1'b0, sync3: 1'b0, tick: 1'b0};
        end else begin
            st_ff <= nxt;
        end
    end

    assign o_tick = st_ff.tick;

endmodule
